// ---- shared/cmp_timer_regs.svh ----
// Constants for the two-channel output-compare timer.
// Included by the package and by the timer design file.
`ifndef CMP_TIMER_REGS_SVH
`define CMP_TIMER_REGS_SVH

// Count clock select codes
`define CKS_FAST        3'h0
`define CKS_SYS         3'h1
`define CKS_DIV2        3'h2
`define CKS_DIV4        3'h3
`define CKS_DIV8        3'h4
`define CKS_DIV32       3'h5
`define CKS_EXT         3'h6

// Divider taps in a 5-bit prescaler
`define TAP_DIV2        0
`define TAP_DIV4        1
`define TAP_DIV8        2
`define TAP_DIV32       4

// Counter clear select codes
`define CLR_NONE        3'h0
`define CLR_GRA         3'h1
`define CLR_GRB         3'h2
`define CLR_SYNC        3'h3
`define CLR_GRC         3'h5
`define CLR_GRD         3'h6

// Compare output action codes
`define OUT_NONE        2'h0
`define OUT_LOW         2'h1
`define OUT_HIGH        2'h2
`define OUT_TOGGLE      2'h3

// Reset values
`define CNT_RESET       16'h0000
`define PRESCALE_RESET  5'h00

`endif

// ---- shared/cmp_timer_pkg.sv ----
// Types shared by the output-compare timer.
// Assumes cmp_timer_regs.svh is on the include path.
`include "cmp_timer_regs.svh"

package cmp_timer_pkg;

  // Per-channel configuration
  typedef struct packed {
    logic [2:0]      clk_sel;
    logic [2:0]      counter_clear_select;
    logic            channel_stop_select;
    logic [3:0][1:0] out_action;
    logic [3:0][15:0] channel_general_reg;
  } chan_cfg_s;

  // Counter write request
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } cnt_wr_s;

  // Channel run state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } run_state_e;

endpackage : cmp_timer_pkg

// ---- rtl/cmp_timer.sv ----
// Two-channel output-compare up-counter timer with four compare registers each.
// Assumes synchronous inputs on mclk; ext and fast clocks arrive as levels.
`timescale 1ns/1ns
`default_nettype none
`include "cmp_timer_regs.svh"

module cmp_timer #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  // Clock sources and enables
  input  wire logic                     timer_clock_supply_enable,
  input  wire logic                     fast_source_select_option,
  input  wire logic                     fast_oscillator_clock,
  input  wire logic                     external_count_clock_in,
  input  wire logic                     external_clock_enable,
  input  wire logic                     sync_operation_bit,
  // Channel configuration
  input  wire cmp_timer_pkg::chan_cfg_s cfg0,
  input  wire cmp_timer_pkg::chan_cfg_s cfg1,
  // Start control
  input  wire logic [1:0]               start_wr,
  input  wire logic [1:0]               start_val,
  // Counter writes
  input  wire cmp_timer_pkg::cnt_wr_s   cnt_wr0,
  input  wire cmp_timer_pkg::cnt_wr_s   cnt_wr1,
  // Status and outputs
  output logic [CW-1:0]                 channel_counter0,
  output logic [CW-1:0]                 channel_counter1,
  output logic [1:0]                    channel_start_bit,
  output logic [1:0][3:0]               compare_out,
  output logic [1:0][3:0]               match_irq,
  output logic [1:0]                    overflow_irq
);
  import cmp_timer_pkg::*;

  // ==========================================================
  // Functions
  function automatic logic next_level(input logic [1:0] act, input logic cur);
    logic r;
    r = cur;
    if (act == `OUT_LOW) begin
      r = 1'b0;
    end else if (act == `OUT_HIGH) begin
      r = 1'b1;
    end else if (act == `OUT_TOGGLE) begin
      r = ~cur;
    end
    return r;
  endfunction : next_level

  function automatic logic clr_hit(input logic [2:0] sel, input logic [3:0] m);
    logic r;
    r = 1'b0;
    if (sel == `CLR_GRA) begin
      r = m[0];
    end else if (sel == `CLR_GRB) begin
      r = m[1];
    end else if (sel == `CLR_GRC) begin
      r = m[2];
    end else if (sel == `CLR_GRD) begin
      r = m[3];
    end
    return r;
  endfunction : clr_hit

  // ==========================================================
  // Prescaler and source edge detection
  logic [4:0] pre_q;
  logic       src_fast_q;
  logic       src_ext_q;
  logic [4:0] pre_d;
  logic       fast_lvl;

  assign pre_d    = pre_q + 5'h01;
  assign fast_lvl = fast_source_select_option ? fast_oscillator_clock : 1'b1;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q      <= `PRESCALE_RESET;
      src_fast_q <= 1'b0;
      src_ext_q  <= 1'b0;
    end else begin
      pre_q      <= timer_clock_supply_enable ? pre_d : `PRESCALE_RESET;
      src_fast_q <= fast_lvl;
      src_ext_q  <= external_count_clock_in;
    end
  end

  logic fast_tick;
  logic ext_tick;
  logic [1:0] tick;

  // Fast source from system clock ticks every cycle
  assign fast_tick = fast_source_select_option ? (fast_lvl & ~src_fast_q) : 1'b1;
  assign ext_tick  = external_clock_enable & external_count_clock_in & ~src_ext_q;

  function automatic logic sel_tick(input logic [2:0] cks, input logic [4:0] p,
                                    input logic ft, input logic et);
    logic r;
    r = 1'b0;
    if (cks == `CKS_FAST) begin
      r = ft;
    end else if (cks == `CKS_SYS) begin
      r = 1'b1;
    end else if (cks == `CKS_DIV2) begin
      r = &p[`TAP_DIV2:0];
    end else if (cks == `CKS_DIV4) begin
      r = &p[`TAP_DIV4:0];
    end else if (cks == `CKS_DIV8) begin
      r = &p[`TAP_DIV8:0];
    end else if (cks == `CKS_DIV32) begin
      r = &p[`TAP_DIV32:0];
    end else if (cks == `CKS_EXT) begin
      r = et;
    end
    return r;
  endfunction : sel_tick

  assign tick[0] = timer_clock_supply_enable
                 & sel_tick(cfg0.clk_sel, pre_q, fast_tick, ext_tick);
  assign tick[1] = timer_clock_supply_enable
                 & sel_tick(cfg1.clk_sel, pre_q, fast_tick, ext_tick);

  // ==========================================================
  // Compare matches and clear decisions
  chan_cfg_s  cfg [2];
  logic [CW-1:0] cnt_q [2];
  logic [1:0][3:0] match;
  logic [1:0] own_clr;
  logic [1:0] clr;
  logic [1:0] ovf;
  logic [1:0] run;

  assign cfg[0] = cfg0;
  assign cfg[1] = cfg1;
  assign cnt_q[0] = channel_counter0;
  assign cnt_q[1] = channel_counter1;

  for (genvar c = 0; c < 2; c++) begin : g_match
    for (genvar g = 0; g < 4; g++) begin : g_reg
      assign match[c][g] = run[c] & tick[c]
                         & (cnt_q[c] == cfg[c].channel_general_reg[g][CW-1:0]);
    end
    assign own_clr[c] = clr_hit(cfg[c].counter_clear_select, match[c]);
    assign ovf[c] = run[c] & tick[c] & (&cnt_q[c]) & ~own_clr[c];
  end

  // Sync clear follows the other channel; none clears with 000B
  assign clr[0] = own_clr[0] | ((cfg0.counter_clear_select == `CLR_SYNC) & own_clr[1]);
  assign clr[1] = own_clr[1] | ((cfg1.counter_clear_select == `CLR_SYNC) & own_clr[0]);

  // ==========================================================
  // Start and stop control
  run_state_e st_q [2];
  logic [1:0] auto_stop;

  assign auto_stop[0] = ~cfg0.channel_stop_select & match[0][0];
  assign auto_stop[1] = ~cfg1.channel_stop_select & match[1][0];

  for (genvar c = 0; c < 2; c++) begin : g_run
    assign run[c] = (st_q[c] == ST_RUN);
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        st_q[c] <= ST_IDLE;
      end else begin
        case (st_q[c])
          ST_IDLE: begin
            if (start_wr[c] && start_val[c]) begin
              st_q[c] <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (start_wr[c] && !start_val[c]) begin
              st_q[c] <= ST_IDLE;
            end else if (auto_stop[c]) begin
              st_q[c] <= ST_IDLE;
            end
          end
          default: st_q[c] <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      channel_start_bit <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (start_wr[c]) begin
          channel_start_bit[c] <= start_val[c];
        end else if (auto_stop[c]) begin
          channel_start_bit[c] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Counters
  logic [1:0] wr_hit;
  logic [CW-1:0] wr_val;

  // In sync mode a write to either counter loads both
  assign wr_hit[0] = cnt_wr0.wr | (sync_operation_bit & cnt_wr1.wr);
  assign wr_hit[1] = cnt_wr1.wr | (sync_operation_bit & cnt_wr0.wr);
  assign wr_val = cnt_wr0.wr ? cnt_wr0.data[CW-1:0] : cnt_wr1.data[CW-1:0];

  function automatic logic [CW-1:0] cnt_next(input logic [CW-1:0] cur, input logic w,
                                             input logic [CW-1:0] wv, input logic cl,
                                             input logic en);
    logic [CW-1:0] r;
    r = cur;
    if (w) begin
      r = wv;
    end else if (cl) begin
      r = '0;
    end else if (en) begin
      r = cur + CW'(1);
    end
    return r;
  endfunction : cnt_next

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      channel_counter0 <= CW'(`CNT_RESET);
      channel_counter1 <= CW'(`CNT_RESET);
    end else begin
      channel_counter0 <= cnt_next(channel_counter0, wr_hit[0],
                          sync_operation_bit ? wr_val : cnt_wr0.data[CW-1:0],
                          clr[0], run[0] & tick[0]);
      channel_counter1 <= cnt_next(channel_counter1, wr_hit[1],
                          sync_operation_bit ? wr_val : cnt_wr1.data[CW-1:0],
                          clr[1], run[1] & tick[1]);
    end
  end

  // ==========================================================
  // Compare outputs and interrupt requests
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      compare_out <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        for (int g = 0; g < 4; g++) begin
          // Pin changes only on a match, so stops hold the level
          if (match[c][g]) begin
            compare_out[c][g] <= next_level(cfg[c].out_action[g],
                                            compare_out[c][g]);
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      match_irq    <= '0;
      overflow_irq <= 2'b00;
    end else begin
      match_irq    <= match;
      overflow_irq <= ovf;
    end
  end

  // ==========================================================
  // Assertions
  start_runs_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start_wr[0] && start_val[0]) |=> channel_start_bit[0])
    else $error("start write did not set start bit");

  no_supply_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!timer_clock_supply_enable && !cnt_wr0.wr && !cnt_wr1.wr)
      |=> $stable(channel_counter0))
    else $error("counter moved without clock supply");

  sw_stop_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start_wr[0] && !start_val[0]) |=> !channel_start_bit[0] && !run[0])
    else $error("software stop ignored");

  auto_stop_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (auto_stop[0] && !start_wr[0]) |=> !run[0] && !channel_start_bit[0])
    else $error("auto stop did not stop channel");

  hold_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !run[0] |=> $stable(compare_out[0]))
    else $error("output moved while stopped");

  sync_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sync_operation_bit && cnt_wr0.wr && !cnt_wr1.wr)
      |=> channel_counter1 == $past(cnt_wr0.data))
    else $error("sync write missed other counter");

  indep_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (!sync_operation_bit && cnt_wr0.wr && !cnt_wr1.wr && !run[1] && !clr[1])
      |=> $stable(channel_counter1))
    else $error("independent write touched other counter");

  free_run_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (cfg0.counter_clear_select == `CLR_NONE && run[0] && tick[0] && !wr_hit[0]
      && !(&channel_counter0)) |=> channel_counter0 == $past(channel_counter0) + 1'b1)
    else $error("free running counter did not increment");

  irq_match_a: assert property (@(posedge mclk) disable iff (!rst_b)
    match[0][0] |=> match_irq[0][0])
    else $error("match interrupt missing");

  sync_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (cfg1.counter_clear_select == `CLR_SYNC && own_clr[0] && !wr_hit[1])
      |=> channel_counter1 == '0)
    else $error("sync clear missed other counter");

  match_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (own_clr[0] && !wr_hit[0]) |=> channel_counter0 == '0)
    else $error("compare clear did not zero counter");

  irq_overflow_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ovf[0] |=> overflow_irq[0])
    else $error("overflow interrupt missing");

  chan1_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (start_wr[1] && start_val[1]) |=> channel_start_bit[1] && run[1])
    else $error("channel one start write ignored");

endmodule : cmp_timer
`default_nettype wire

// ---- bench/timer_output_compare_counter_tb.sv ----
// Testbench for the two-channel output-compare timer.
// Assumes cmp_timer_pkg and cmp_timer_regs.svh are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "cmp_timer_regs.svh"

module timer_output_compare_counter_tb;
  import cmp_timer_pkg::*;

  // ==========
  // Signals
  logic            mclk, rst_b, supply, opt, ext_en, sync;
  logic [3:0]      cyc;
  chan_cfg_s       cfg0, cfg1;
  logic [1:0]      start_wr, start_val, sbit, ovf;
  cnt_wr_s         cnt_wr0, cnt_wr1;
  logic [15:0]     cnt0, cnt1, v;
  logic [1:0][3:0] cmp_o, mirq;
  logic [3:0]      ob;
  logic            o;
  int              n, failures, n_checks;

  // Clock select table: {supply, option, ext enable} and ticks per 64 cycles
  logic [2:0]  cs_t [10] = '{`CKS_FAST, `CKS_SYS, `CKS_DIV2, `CKS_DIV4, `CKS_DIV8,
                             `CKS_DIV32, `CKS_FAST, `CKS_EXT, `CKS_EXT, `CKS_SYS};
  logic [2:0]  fl_t [10] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h6, 3'h4, 3'h5, 3'h0};
  logic [15:0] ex_t [10] = '{16'h0040, 16'h0040, 16'h0020, 16'h0010, 16'h0008,
                             16'h0002, 16'h0010, 16'h0000, 16'h0010, 16'h0000};
  logic [2:0]  clr_t [4] = '{`CLR_GRA, `CLR_GRB, `CLR_GRC, `CLR_GRD};

  // ==========
  // Design
  cmp_timer u_cmp_timer (
    .mclk                      (mclk),
    .rst_b                     (rst_b),
    .timer_clock_supply_enable (supply),
    .fast_source_select_option (opt),
    .fast_oscillator_clock     (cyc[1]),
    .external_count_clock_in   (cyc[1]),
    .external_clock_enable     (ext_en),
    .sync_operation_bit        (sync),
    .cfg0                      (cfg0),
    .cfg1                      (cfg1),
    .start_wr                  (start_wr),
    .start_val                 (start_val),
    .cnt_wr0                   (cnt_wr0),
    .cnt_wr1                   (cnt_wr1),
    .channel_counter0          (cnt0),
    .channel_counter1          (cnt1),
    .channel_start_bit         (sbit),
    .compare_out               (cmp_o),
    .match_irq                 (mirq),
    .overflow_irq              (ovf)
  );

  // ==========
  // Clocks
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    cyc <= cyc + 4'h1;
  end

  // ==========
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask : tick

  task automatic set_cfg(input int ch, input logic [2:0] cs, input logic [2:0] clr,
                         input logic ss, input int j, input logic [1:0] act);
    chan_cfg_s c;
    c.clk_sel = cs;
    c.counter_clear_select = clr;
    c.channel_stop_select = ss;
    for (int k = 0; k < 4; k++) begin
      c.out_action[k] = act;
      c.channel_general_reg[k] = 16'h8000;
    end
    c.channel_general_reg[j] = 16'h0005;
    if (ch == 0) cfg0 = c;
    else cfg1 = c;
  endtask : set_cfg

  task automatic start(input logic [1:0] m, input logic [1:0] val);
    start_wr = m;
    start_val = val;
    tick(1);
    start_wr = 2'h0;
  endtask : start

  task automatic wcnt(input int ch, input logic [15:0] d);
    if (ch == 0) cnt_wr0 = {1'b1, d};
    else cnt_wr1 = {1'b1, d};
    tick(1);
    if (ch == 0) begin
      cnt_wr0.wr = 1'b0;
    end else begin
      cnt_wr1.wr = 1'b0;
    end
  endtask : wcnt

  task automatic wait_m(input int j, output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (mirq[0][j] !== 1'b1 && k < 100);
    if (k == 100) check(16'h0000, 16'h0001);
  endtask : wait_m

  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // ==========
  // Tests
  initial begin
    cyc = 4'h0;
    rst_b = 1'b0;
    supply = 1'b1;
    opt = 1'b0;
    ext_en = 1'b0;
    sync = 1'b0;
    start_wr = 2'h0;
    start_val = 2'h0;
    cnt_wr0 = '0;
    cnt_wr1 = '0;
    failures = 0;
    n_checks = 0;
    set_cfg(0, `CKS_SYS, `CLR_NONE, 1'b1, 0, `OUT_TOGGLE);
    set_cfg(1, `CKS_SYS, `CLR_NONE, 1'b1, 0, `OUT_TOGGLE);
    tick(6);
    rst_b = 1'b1;
    tick(1);
    check(cnt0, 16'h0000);
    check({6'h00, sbit, cmp_o}, 16'h0000);
    // Count clock sources and supply gating
    start(2'h1, 2'h1);
    check({15'h0000, sbit[0]}, 16'h0001);
    for (int i = 0; i < 10; i++) begin
      set_cfg(0, cs_t[i], `CLR_NONE, 1'b1, 0, `OUT_TOGGLE);
      {supply, opt, ext_en} = fl_t[i];
      tick(3);
      v = cnt0;
      tick(64);
      check(cnt0 - v, ex_t[i]);
    end
    {supply, opt, ext_en} = 3'h4;
    // Overflow
    set_cfg(0, `CKS_SYS, `CLR_NONE, 1'b1, 0, `OUT_TOGGLE);
    wcnt(0, 16'hFFFD);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (ovf[0] !== 1'b1 && n < 10);
    check(16'(n), 16'h0003);
    check(cnt0, 16'h0000);
    // Every compare clear code
    for (int j = 0; j < 4; j++) begin
      set_cfg(0, `CKS_SYS, clr_t[j], 1'b1, j, `OUT_TOGGLE);
      wcnt(0, 16'h0000);
      wait_m(j, n);
      check(cnt0, 16'h0000);
      o = cmp_o[0][j];
      wait_m(j, n);
      check(16'(n), 16'h0006);
      check({15'h0000, cmp_o[0][j]}, {15'h0000, ~o});
    end
    // Clear follows the other channel
    set_cfg(1, `CKS_SYS, `CLR_SYNC, 1'b1, 0, `OUT_TOGGLE);
    set_cfg(0, `CKS_SYS, `CLR_GRA, 1'b1, 0, `OUT_TOGGLE);
    wcnt(1, 16'h0100);
    start(2'h2, 2'h2);
    wcnt(0, 16'h0000);
    wait_m(0, n);
    check(cnt1, 16'h0000);
    tick(6);
    check({15'h0000, mirq[1][0]}, 16'h0001);
    check(cnt1, 16'h0000);
    // Software stop holds count and pins
    start(2'h3, 2'h0);
    check({14'h0000, sbit}, 16'h0000);
    v = cnt0;
    ob = cmp_o[0];
    tick(20);
    check(cnt0, v);
    check({12'h000, cmp_o[0]}, {12'h000, ob});
    // Counter writes, independent and linked
    wcnt(1, 16'h1234);
    check(cnt0, v);
    check(cnt1, 16'h1234);
    sync = 1'b1;
    wcnt(0, 16'hABCD);
    check(cnt1, 16'hABCD);
    wcnt(1, 16'h0F0F);
    check(cnt0, 16'h0F0F);
    check(cnt1, 16'h0F0F);
    sync = 1'b0;
    // Stop on register A match
    o = cmp_o[0][0];
    set_cfg(0, `CKS_SYS, `CLR_NONE, 1'b0, 0, o ? `OUT_LOW : `OUT_HIGH);
    wcnt(0, 16'h0000);
    start(2'h1, 2'h1);
    wait_m(0, n);
    check({15'h0000, sbit[0]}, 16'h0000);
    check({15'h0000, cmp_o[0][0]}, {15'h0000, ~o});
    v = cnt0;
    tick(10);
    check(cnt0, v);
    check({15'h0000, cmp_o[0][0]}, {15'h0000, ~o});
    results;
  end

  // ==========
  // Watchdog
  initial begin
    #100000;
    failures++;
    results;
  end

endmodule : timer_output_compare_counter_tb
`default_nettype wire
